/* rtl/gpio_ports_c_d_e.sv */
// gpio ports c, d and e behind an apb slave, with pins shared by spi, timer, sci and adc
// assumes: peripheral enables and alternate drive come from logic on clk;
// pins are asynchronous and resolved outside from out/oe pairs
//
// How it works
// - port c direction bit one drives the pin, zero leaves it a floating input, except pin 2, which drives while the bus clock is out
// - bit 7 of port c direction sends bus clock out on pin 2
// - reset clears every port c direction bit and the bus clock enable
// - port c data reads latch where output, pin where input, but pin 2 reads latch while the clock is out, else zero; writes skip pin 2 then
// - port d holds six latch bits steered by port d direction
// - adc-selected port d pins 0..3 read zero as inputs, latch as outputs
// - adc-selected port d pins never drive, whatever their direction bit
// - port d direction bit one drives; reset clears all six
// - port d data reads latch where output, pin where input; writes always land
// - port e holds eight latch bits that reset leaves alone
// - pin e7 is spi clock while spi enabled, gpio otherwise
// - pins e6 and e5 are spi data lines while spi enabled
// - pin e4 is spi slave select unless spi off or master without fault detect
// - pins e3 and e2 are timer channels when their edge level field is nonzero
// - pins e1 and e0 are sci receive and transmit while sci enabled
// - peripheral-owned pins ignore direction for drive but not for reads
// - port e direction bit one drives; reset clears all eight
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cfg.svh"

module gpio_ports_c_d_e (
	input  wire logic                       clk,
	input  wire logic                       rst,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [`GPIO_ADDR_W-1:0]    paddr,
	input  wire logic [31:0]                pwdata,
	output var  logic [31:0]                prdata,
	output var  logic                       pready,
	output var  logic                       pslverr,
	// peripheral ownership controls
	input  wire logic                       spi_enable,
	input  wire logic                       spi_master_select,
	input  wire logic                       mode_fault_enable,
	input  wire logic [4:0]                 adc_channel_select,
	input  wire logic [1:0]                 edge_level_select_ch0,
	input  wire logic [1:0]                 edge_level_select_ch1,
	input  wire logic                       sci_enable,
	// alternate drive for port e from spi, timer and sci
	input  wire logic [`GPIO_E_WIDTH-1:0]   port_e_alt_out,
	input  wire logic [`GPIO_E_WIDTH-1:0]   port_e_alt_oe,
	// pins
	input  wire logic [`GPIO_C_WIDTH-1:0]   port_c_pin_in,
	output var  logic [`GPIO_C_WIDTH-1:0]   port_c_pin_out,
	output var  logic [`GPIO_C_WIDTH-1:0]   port_c_pin_oe,
	input  wire logic [`GPIO_D_WIDTH-1:0]   port_d_pin_in,
	output var  logic [`GPIO_D_WIDTH-1:0]   port_d_pin_out,
	output var  logic [`GPIO_D_WIDTH-1:0]   port_d_pin_oe,
	input  wire logic [`GPIO_E_WIDTH-1:0]   port_e_pin_in,
	output var  logic [`GPIO_E_WIDTH-1:0]   port_e_pin_out,
	output var  logic [`GPIO_E_WIDTH-1:0]   port_e_pin_oe,
	// synchronised port e levels for the peripherals that listen on them
	output var  logic [`GPIO_E_WIDTH-1:0]   port_e_pin_sync
);

	// register state
	logic [`GPIO_C_WIDTH-1:0] port_c_latch_ff;
	logic [`GPIO_C_WIDTH-1:0] port_c_direction_ff;
	logic                     bus_clock_out_enable_ff;
	logic [`GPIO_D_WIDTH-1:0] port_d_latch_ff;
	logic [`GPIO_D_WIDTH-1:0] port_d_direction_ff;
	logic [`GPIO_E_WIDTH-1:0] port_e_latch_ff;
	logic [`GPIO_E_WIDTH-1:0] port_e_direction_ff;
	logic                     bus_clock_ff;

	// bus side
	logic [31:0]              nxt_prdata;
	logic                     nxt_pslverr;
	logic                     setup_phase;
	logic                     write_strobe;
	gpio_pkg::reg_sel_type    setup_sel;
	gpio_pkg::reg_sel_type    access_sel;

	// pin side
	logic [`GPIO_C_WIDTH-1:0] port_c_owned;
	logic [`GPIO_C_WIDTH-1:0] port_c_alt_out;
	logic [`GPIO_C_WIDTH-1:0] port_c_alt_oe;
	logic [`GPIO_C_WIDTH-1:0] port_c_read;
	logic [`GPIO_D_WIDTH-1:0] port_d_adc_use;
	logic [`GPIO_D_WIDTH-1:0] port_d_read;
	logic [`GPIO_E_WIDTH-1:0] port_e_owned;
	logic [`GPIO_E_WIDTH-1:0] port_e_input_only;
	logic [`GPIO_E_WIDTH-1:0] port_e_drive_oe;
	logic [`GPIO_E_WIDTH-1:0] port_e_read;
	logic                     spi_ss_owned;

	// word index times four is the byte address; anything else is unmapped
	function automatic gpio_pkg::reg_sel_type decode_addr(
		input logic [`GPIO_ADDR_W-1:0] addr
	);
		gpio_pkg::reg_sel_type sel;
		sel = gpio_pkg::sel_none;
		if (addr[1:0] == 2'h0) begin
			unique case (addr >> 2)
				`GPIO_IDX_C_LATCH: sel = gpio_pkg::sel_c_latch;
				`GPIO_IDX_C_DIR:   sel = gpio_pkg::sel_c_dir;
				`GPIO_IDX_D_LATCH: sel = gpio_pkg::sel_d_latch;
				`GPIO_IDX_D_DIR:   sel = gpio_pkg::sel_d_dir;
				`GPIO_IDX_E_LATCH: sel = gpio_pkg::sel_e_latch;
				`GPIO_IDX_E_DIR:   sel = gpio_pkg::sel_e_dir;
				default:           sel = gpio_pkg::sel_none;
			endcase
		end
		return sel;
	endfunction : decode_addr

	assign setup_sel    = decode_addr(paddr);
	assign access_sel   = decode_addr(paddr);
	assign setup_phase  = psel && !penable;
	// one wait-free access: pready is raised in the cycle after setup
	assign write_strobe = psel && penable && pready && pwrite;

	// apb answer
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
		end else begin
			pready <= setup_phase;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			pslverr <= nxt_pslverr;
		end else begin
			pslverr <= 1'b0;
		end
	end

	// read data is captured at the setup edge, so pins are sampled one cycle early
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (setup_phase && !pwrite) begin
			prdata <= nxt_prdata;
		end
	end

	always_comb begin
		nxt_pslverr = (setup_sel == gpio_pkg::sel_none);
		nxt_prdata  = 32'h0000_0000;
		unique case (setup_sel)
			gpio_pkg::sel_c_latch: nxt_prdata[`GPIO_C_WIDTH-1:0] = port_c_read;
			gpio_pkg::sel_c_dir: begin
				nxt_prdata[`GPIO_C_WIDTH-1:0]        = port_c_direction_ff;
				nxt_prdata[`GPIO_C_BUSCLK_EN_BIT]    = bus_clock_out_enable_ff;
			end
			gpio_pkg::sel_d_latch: nxt_prdata[`GPIO_D_WIDTH-1:0] = port_d_read;
			gpio_pkg::sel_d_dir:   nxt_prdata[`GPIO_D_WIDTH-1:0] = port_d_direction_ff;
			gpio_pkg::sel_e_latch: nxt_prdata[`GPIO_E_WIDTH-1:0] = port_e_read;
			gpio_pkg::sel_e_dir:   nxt_prdata[`GPIO_E_WIDTH-1:0] = port_e_direction_ff;
			gpio_pkg::sel_none:    nxt_prdata = 32'h0000_0000;
		endcase
	end

	// port c data latch: no reset, pin 2 frozen while the bus clock is out
	always_ff @(posedge clk) begin
		if (write_strobe && access_sel == gpio_pkg::sel_c_latch) begin
			for (int b = 0; b < `GPIO_C_WIDTH; b++) begin
				if (b != `GPIO_C_BUSCLK_PIN || !bus_clock_out_enable_ff) begin
					port_c_latch_ff[b] <= pwdata[b];
				end
			end
		end
	end

	// port c direction and bus clock enable
	always_ff @(posedge clk) begin
		if (rst) begin
			port_c_direction_ff     <= `GPIO_C_WIDTH'(`GPIO_DIR_RESET);
			bus_clock_out_enable_ff <= `GPIO_BUSCLK_EN_RESET;
		end else if (write_strobe && access_sel == gpio_pkg::sel_c_dir) begin
			port_c_direction_ff     <= pwdata[`GPIO_C_WIDTH-1:0];
			bus_clock_out_enable_ff <= pwdata[`GPIO_C_BUSCLK_EN_BIT];
		end
	end

	// port d data latch, reset leaves it alone
	always_ff @(posedge clk) begin
		if (write_strobe && access_sel == gpio_pkg::sel_d_latch) begin
			port_d_latch_ff <= pwdata[`GPIO_D_WIDTH-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			port_d_direction_ff <= `GPIO_D_WIDTH'(`GPIO_DIR_RESET);
		end else if (write_strobe && access_sel == gpio_pkg::sel_d_dir) begin
			port_d_direction_ff <= pwdata[`GPIO_D_WIDTH-1:0];
		end
	end

	// port e data latch, reset leaves it alone
	always_ff @(posedge clk) begin
		if (write_strobe && access_sel == gpio_pkg::sel_e_latch) begin
			port_e_latch_ff <= pwdata[`GPIO_E_WIDTH-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			port_e_direction_ff <= `GPIO_DIR_RESET;
		end else if (write_strobe && access_sel == gpio_pkg::sel_e_dir) begin
			port_e_direction_ff <= pwdata[`GPIO_E_WIDTH-1:0];
		end
	end

	// stand-in for the bus clock: a registered half-rate toggle keeps the pin glitch-free
	always_ff @(posedge clk) begin
		if (rst) begin
			bus_clock_ff <= 1'b0;
		end else begin
			bus_clock_ff <= !bus_clock_ff;
		end
	end

	// port c: only pin 2 has an alternate use
	always_comb begin
		port_c_owned   = '0;
		port_c_alt_out = '0;
		port_c_alt_oe  = '0;
		port_c_owned[`GPIO_C_BUSCLK_PIN]   = bus_clock_out_enable_ff;
		port_c_alt_out[`GPIO_C_BUSCLK_PIN] = bus_clock_ff;
		port_c_alt_oe[`GPIO_C_BUSCLK_PIN]  = 1'b1;
	end

	logic [`GPIO_C_WIDTH-1:0] port_c_bank_read;

	always_comb begin
		port_c_read = port_c_bank_read;
		port_c_read[`GPIO_C_BUSCLK_PIN] = bus_clock_out_enable_ff
			? port_c_latch_ff[`GPIO_C_BUSCLK_PIN] : 1'b0;
	end

	// port d: pins 0..3 are adc channels 8..11
	always_comb begin
		port_d_adc_use = '0;
		for (int b = 0; b < `GPIO_ADC_D_PINS; b++) begin
			port_d_adc_use[b] = (adc_channel_select == (`GPIO_ADC_FIRST_D_CH + 5'(b)));
		end
	end

	// port e ownership
	assign spi_ss_owned = spi_enable && !(spi_master_select && !mode_fault_enable);

	always_comb begin
		port_e_owned[7] = spi_enable;
		port_e_owned[6] = spi_enable;
		port_e_owned[5] = spi_enable;
		port_e_owned[4] = spi_ss_owned;
		port_e_owned[3] = |edge_level_select_ch1;
		port_e_owned[2] = |edge_level_select_ch0;
		port_e_owned[1] = sci_enable;
		port_e_owned[0] = sci_enable;
	end

	// slave select and receive data are inputs whatever the peripheral asks for
	always_comb begin
		port_e_input_only    = '0;
		port_e_input_only[4] = 1'b1;
		port_e_input_only[1] = 1'b1;
		port_e_drive_oe      = port_e_alt_oe & ~port_e_input_only;
	end

	pin_bank #(
		.WIDTH(`GPIO_C_WIDTH)
	) u_port_c (
		.clk           (clk),
		.rst           (rst),
		.latch         (port_c_latch_ff),
		.dir           (port_c_direction_ff),
		.owned         (port_c_owned),
		.alt_out       (port_c_alt_out),
		.alt_oe        (port_c_alt_oe),
		.zero_on_input ('0),
		.pin_in        (port_c_pin_in),
		.pin_out       (port_c_pin_out),
		.pin_oe        (port_c_pin_oe),
		.pin_sync      (),
		.read_val      (port_c_bank_read)
	);

	// adc pins are owned with no drive, so they stay floating inputs
	pin_bank #(
		.WIDTH(`GPIO_D_WIDTH)
	) u_port_d (
		.clk           (clk),
		.rst           (rst),
		.latch         (port_d_latch_ff),
		.dir           (port_d_direction_ff),
		.owned         (port_d_adc_use),
		.alt_out       ('0),
		.alt_oe        ('0),
		.zero_on_input (port_d_adc_use),
		.pin_in        (port_d_pin_in),
		.pin_out       (port_d_pin_out),
		.pin_oe        (port_d_pin_oe),
		.pin_sync      (),
		.read_val      (port_d_read)
	);

	pin_bank #(
		.WIDTH(`GPIO_E_WIDTH)
	) u_port_e (
		.clk           (clk),
		.rst           (rst),
		.latch         (port_e_latch_ff),
		.dir           (port_e_direction_ff),
		.owned         (port_e_owned),
		.alt_out       (port_e_alt_out),
		.alt_oe        (port_e_drive_oe),
		.zero_on_input ('0),
		.pin_in        (port_e_pin_in),
		.pin_out       (port_e_pin_out),
		.pin_oe        (port_e_pin_oe),
		.pin_sync      (port_e_pin_sync),
		.read_val      (port_e_read)
	);

endmodule : gpio_ports_c_d_e

`default_nettype wire

/* rtl/gpio_cfg.svh */
// register indices, field positions, reset values and widths for the gpio ports
// assumes: included by bare name from files under rtl/
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

`define GPIO_ADDR_W          8
`define GPIO_IDX_C_LATCH     8'h02
`define GPIO_IDX_D_LATCH     8'h03
`define GPIO_IDX_C_DIR       8'h06
`define GPIO_IDX_D_DIR       8'h07
`define GPIO_IDX_E_LATCH     8'h08
`define GPIO_IDX_E_DIR       8'h0c
`define GPIO_C_WIDTH         5
`define GPIO_D_WIDTH         6
`define GPIO_E_WIDTH         8
`define GPIO_C_BUSCLK_PIN    2
`define GPIO_C_BUSCLK_EN_BIT 7
`define GPIO_DIR_RESET       8'h00
`define GPIO_BUSCLK_EN_RESET 1'b0
`define GPIO_ADC_FIRST_D_CH  5'h08
`define GPIO_ADC_D_PINS      4

`endif

/* rtl/gpio_pkg.sv */
// types shared by the gpio port block
// assumes: constants come from gpio_cfg.svh
package gpio_pkg;

	typedef enum logic [2:0] {
		sel_none    = 3'b000,
		sel_c_latch = 3'b001,
		sel_c_dir   = 3'b010,
		sel_d_latch = 3'b011,
		sel_d_dir   = 3'b100,
		sel_e_latch = 3'b101,
		sel_e_dir   = 3'b110
	} reg_sel_type;

endpackage : gpio_pkg

/* rtl/pin_bank.sv */
// one port's pin cells: input synchronisers, registered drive and read mux
// assumes: clk domain logic feeds latch, direction and ownership; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none

module pin_bank #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] latch,
	input  wire logic [WIDTH-1:0] dir,
	input  wire logic [WIDTH-1:0] owned,
	input  wire logic [WIDTH-1:0] alt_out,
	input  wire logic [WIDTH-1:0] alt_oe,
	input  wire logic [WIDTH-1:0] zero_on_input,
	input  wire logic [WIDTH-1:0] pin_in,
	output var  logic [WIDTH-1:0] pin_out,
	output var  logic [WIDTH-1:0] pin_oe,
	output var  logic [WIDTH-1:0] pin_sync,
	output var  logic [WIDTH-1:0] read_val
);

	logic [WIDTH-1:0] meta_ff;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_cell
			// first stage is read only by the second
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_ff[i]  <= 1'b0;
					pin_sync[i] <= 1'b0;
				end else begin
					meta_ff[i]  <= pin_in[i];
					pin_sync[i] <= meta_ff[i];
				end
			end

			// a peripheral that owns the pin decides its direction itself
			always_ff @(posedge clk) begin
				if (rst) begin
					pin_oe[i] <= 1'b0;
				end else begin
					pin_oe[i] <= owned[i] ? alt_oe[i] : dir[i];
				end
			end

			always_ff @(posedge clk) begin
				if (rst) begin
					pin_out[i] <= 1'b0;
				end else begin
					pin_out[i] <= owned[i] ? alt_out[i] : latch[i];
				end
			end

			// direction bit picks latch on reads, else pin unless zero_on_input forces zero
			always_comb begin
				if (dir[i]) begin
					read_val[i] = latch[i];
				end else if (zero_on_input[i]) begin
					read_val[i] = 1'b0;
				end else begin
					read_val[i] = pin_sync[i];
				end
			end
		end
	endgenerate

endmodule : pin_bank

`default_nettype wire

/* verif/pin_partner.sv */
// board side of one port: resolves each pin wire from block and board drive
// assumes: ext_level is what the board puts on pins the block leaves free
`timescale 1ns/1ps
`default_nettype none
module pin_partner #(
	parameter int WIDTH = 8
) (
	input  wire logic [WIDTH-1:0] pin_out,
	input  wire logic [WIDTH-1:0] pin_oe,
	input  wire logic [WIDTH-1:0] ext_level,
	output var  logic [WIDTH-1:0] pin_level
);
	// block wins where it drives; contention is not modelled
	assign pin_level = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule : pin_partner
`default_nettype wire

/* verif/gpio_ports_c_d_e_asserts.sv */
// concurrent checks on the apb and pin ports of the gpio block
// assumes: bound to gpio_ports_c_d_e; one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cfg.svh"
module gpio_ports_c_d_e_asserts (
	input wire logic                     clk,
	input wire logic                     rst,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [`GPIO_ADDR_W-1:0]  paddr,
	input wire logic [31:0]              pwdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire logic                     spi_enable,
	input wire logic                     spi_master_select,
	input wire logic                     mode_fault_enable,
	input wire logic [4:0]               adc_channel_select,
	input wire logic [1:0]               edge_level_select_ch0,
	input wire logic                     sci_enable,
	input wire logic [`GPIO_E_WIDTH-1:0] port_e_alt_out,
	input wire logic [`GPIO_E_WIDTH-1:0] port_e_alt_oe,
	input wire logic [`GPIO_C_WIDTH-1:0] port_c_pin_oe,
	input wire logic [`GPIO_D_WIDTH-1:0] port_d_pin_oe,
	input wire logic [`GPIO_E_WIDTH-1:0] port_e_pin_out,
	input wire logic [`GPIO_E_WIDTH-1:0] port_e_pin_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	chk_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	chk_err_ready: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside access phase");
	chk_reset_quiet: assert property (disable iff (1'b0) rst |=>
		port_c_pin_oe == '0 && port_d_pin_oe == '0 && port_e_pin_oe == '0)
		else $error("pin driven after reset");
	chk_c_dir_drive: assert property (psel && penable && pready && pwrite
		&& paddr == (`GPIO_IDX_C_DIR << 2) |-> ##2
		{port_c_pin_oe[4:3], port_c_pin_oe[1:0]} == $past({pwdata[4:3], pwdata[1:0]}, 2))
		else $error("port c drive not per direction");
	chk_busclk_drive: assert property (psel && penable && pready && pwrite
		&& paddr == (`GPIO_IDX_C_DIR << 2) && pwdata[`GPIO_C_BUSCLK_EN_BIT]
		|-> ##2 port_c_pin_oe[`GPIO_C_BUSCLK_PIN])
		else $error("bus clock pin not driven");
	chk_adc_hiz: assert property (adc_channel_select inside {[5'h08:5'h0b]} |=>
		!port_d_pin_oe[$past(adc_channel_select[1:0])])
		else $error("adc pin driven");
	chk_rx_input: assert property (sci_enable |=> !port_e_pin_oe[1])
		else $error("receive pin driven");
	chk_ss_input: assert property (spi_enable && !(spi_master_select
		&& !mode_fault_enable) |=> !port_e_pin_oe[4])
		else $error("slave select pin driven");
	chk_sck_alt: assert property (spi_enable |=>
		port_e_pin_oe[7] == $past(port_e_alt_oe[7])
		&& port_e_pin_out[7] == $past(port_e_alt_out[7]))
		else $error("spi clock pin not from spi");
	chk_tch0_alt: assert property (edge_level_select_ch0 != 2'b00 |=>
		port_e_pin_oe[2] == $past(port_e_alt_oe[2]))
		else $error("timer pin not from timer");
endmodule : gpio_ports_c_d_e_asserts

bind gpio_ports_c_d_e gpio_ports_c_d_e_asserts chk (.clk, .rst, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .pslverr, .spi_enable, .spi_master_select, .mode_fault_enable,
	.adc_channel_select, .edge_level_select_ch0, .sci_enable, .port_e_alt_out, .port_e_alt_oe,
	.port_c_pin_oe, .port_d_pin_oe, .port_e_pin_out, .port_e_pin_oe);
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the gpio block: apb master, board pins, peripheral owners
// assumes: design answers each apb access; pins resolved by pin_partner
`timescale 1ns/1ps
`default_nettype none
`include "gpio_cfg.svh"
module testbench;
	logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, b;
	logic        spi_enable = 1'b0, spi_master_select = 1'b0, mode_fault_enable = 1'b0;
	logic        sci_enable = 1'b0;
	logic [4:0]  adc_channel_select = 5'h00;
	logic [1:0]  edge_level_select_ch0 = 2'b00, edge_level_select_ch1 = 2'b00;
	logic [7:0]  port_e_alt_out = 8'h00, port_e_alt_oe = 8'h00;
	logic [4:0]  port_c_pin_in, port_c_pin_out, port_c_pin_oe, c_ext = 5'h00;
	logic [5:0]  port_d_pin_in, port_d_pin_out, port_d_pin_oe, d_ext = 6'h00;
	logic [7:0]  port_e_pin_in, port_e_pin_out, port_e_pin_oe, port_e_pin_sync, e_ext = 8'h00;
	int          fails = 0, n_compared = 0;
	localparam logic [7:0] a_cl = `GPIO_IDX_C_LATCH << 2, a_cd = `GPIO_IDX_C_DIR << 2;
	localparam logic [7:0] a_dl = `GPIO_IDX_D_LATCH << 2, a_dd = `GPIO_IDX_D_DIR << 2;
	localparam logic [7:0] a_el = `GPIO_IDX_E_LATCH << 2, a_ed = `GPIO_IDX_E_DIR << 2;
	// owner setting {spi on, master, fault detect, sci on, timer 1 sel, timer 0 sel}
	// and the expected drive with every direction bit one
	logic [15:0] mode_tab [0:6] = '{16'h00ff, 16'h800f, 16'hc01f, 16'he00f, 16'h01fb,
		16'h0cf7, 16'h10fc};

	gpio_ports_c_d_e DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .spi_enable, .spi_master_select, .mode_fault_enable,
		.adc_channel_select, .edge_level_select_ch0, .edge_level_select_ch1, .sci_enable,
		.port_e_alt_out, .port_e_alt_oe, .port_c_pin_in, .port_c_pin_out, .port_c_pin_oe,
		.port_d_pin_in, .port_d_pin_out, .port_d_pin_oe, .port_e_pin_in, .port_e_pin_out,
		.port_e_pin_oe, .port_e_pin_sync);
	pin_partner #(.WIDTH(5)) board_c (.pin_out(port_c_pin_out), .pin_oe(port_c_pin_oe),
		.ext_level(c_ext), .pin_level(port_c_pin_in));
	pin_partner #(.WIDTH(6)) board_d (.pin_out(port_d_pin_out), .pin_oe(port_d_pin_oe),
		.ext_level(d_ext), .pin_level(port_d_pin_in));
	pin_partner #(.WIDTH(8)) board_e (.pin_out(port_e_pin_out), .pin_oe(port_e_pin_oe),
		.ext_level(e_ext), .pin_level(port_e_pin_in));

	initial begin
		forever #10 clk = ~clk;
	end

	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (i = 0; i < 10; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 10) begin
			fails++;
			stop_test();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
		check(err, 32'h0);
	endtask : rd_chk

	// let the edge's updates land before looking
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle

	task automatic t_reset();
		rd_chk(a_cd, 32'h0);
		rd_chk(a_dd, 32'h0);
		rd_chk(a_ed, 32'h0);
		check(port_c_pin_oe, 32'h0);
		check(port_d_pin_oe, 32'h0);
		check(port_e_pin_oe, 32'h0);
		apb(1'b1, a_el, 32'ha5);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		apb(1'b1, 8'h21, 32'h00);
		check(err, 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		check(err, 32'h1);
		check(rd, 32'h0);
		apb(1'b1, a_ed, 32'hff);
		rd_chk(a_el, 32'ha5);
	endtask : t_reset

	task automatic t_port_c();
		c_ext <= 5'h04;
		apb(1'b1, a_cl, 32'h1f);
		apb(1'b1, a_cd, 32'h19);
		settle(3);
		check(port_c_pin_oe & port_c_pin_out, 32'h19);
		// pin 2 is high on the board and in the latch, yet reads zero
		rd_chk(a_cl, 32'h19);
		apb(1'b1, a_cd, 32'h99);
		rd_chk(a_cd, 32'h99);
		settle(1);
		b = port_c_pin_out[2];
		settle(1);
		check({port_c_pin_oe[2], port_c_pin_out[2]}, {1'b1, ~b});
		// clearing write must leave latch bit 2 set while the clock is out
		apb(1'b1, a_cl, 32'h00);
		rd_chk(a_cl, 32'h04);
		apb(1'b1, a_cd, 32'h00);
	endtask : t_port_c

	task automatic t_port_d();
		d_ext <= 6'h3f;
		apb(1'b1, a_dl, 32'h2a);
		apb(1'b1, a_dd, 32'h0f);
		for (int k = 0; k < 5; k++) begin
			@(posedge clk);
			adc_channel_select <= 5'(8 + k);
			settle(2);
			check(port_d_pin_oe, 6'h0f & ~(6'h01 << k));
		end
		check(port_d_pin_out, 32'h2a);
		@(posedge clk);
		adc_channel_select <= 5'h09;
		rd_chk(a_dl, 32'h3a);
		apb(1'b1, a_dd, 32'h00);
		// released pins need the drive edge plus two sync stages before reads see them
		settle(3);
		rd_chk(a_dl, 32'h3d);
	endtask : t_port_d

	task automatic t_port_e();
		e_ext <= 8'h3c;
		apb(1'b1, a_el, 32'h5a);
		apb(1'b1, a_ed, 32'hff);
		for (int k = 0; k < 7; k++) begin
			@(posedge clk);
			{spi_enable, spi_master_select, mode_fault_enable, sci_enable,
				edge_level_select_ch1, edge_level_select_ch0} <= mode_tab[k][15:8];
			settle(2);
			check(port_e_pin_oe, mode_tab[k][7:0]);
		end
		@(posedge clk);
		{spi_enable, sci_enable, edge_level_select_ch1, edge_level_select_ch0} <= 6'h35;
		rd_chk(a_el, 32'h5a);
		check(port_e_pin_oe, 32'h0);
		apb(1'b1, a_ed, 32'h00);
		port_e_alt_oe <= 8'hff;
		port_e_alt_out <= 8'h81;
		// peripherals now drive all but e4 and e1, which show the board level
		settle(3);
		rd_chk(a_el, 32'h91);
		check(port_e_pin_sync, 32'h91);
		settle(1);
		check({port_e_pin_oe, port_e_pin_out & port_e_pin_oe}, 16'hed81);
	endtask : t_port_e

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_port_c();
		t_port_d();
		t_port_e();
		stop_test();
	end
endmodule : testbench
`default_nettype wire
